// File: design/ctoc_pkg.sv
// What this block does
// - Mode register, read/write, index 8h, resets zero
// - Code 00 halts both counters
// - Code 05 halts long counter, short starts if idle or keeps running
// - Code 61 starts 16-bit counter on the write
// - 16-bit terminal count sets long expiry flag
// - Code 65 arms short counter on start bit
// - Short expiry sets flag, counter auto-reloads
// - Code 65 starts 16-bit at once, long flag
// - Zero stops both counters in code 65
// - Code 68 runs 24-bit chain from the write
// - Code 71 starts 16-bit on every start bit
// - Code 71 new reloads apply at next start
// - Write-only reload bytes at indices 9h, Ah, Bh
//
// Purpose: Shared constants and types of the card timeout counter.
// Assumes: Registers sit one per aligned 32-bit APB word.
// Notes:   Byte address is four times the register index.
package ctoc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [5:0] CTOC_IDX_MODE   = 6'h08; // Mode select
  localparam logic [5:0] CTOC_IDX_LOW    = 6'h09; // Reload low byte
  localparam logic [5:0] CTOC_IDX_MID    = 6'h0a; // Reload mid byte
  localparam logic [5:0] CTOC_IDX_HIGH   = 6'h0b; // Reload high byte
  localparam logic [5:0] CTOC_IDX_STATUS = 6'h0c; // Expiry flags
  localparam logic [7:0] CTOC_ADDR_MODE  = {CTOC_IDX_MODE, 2'b00};

  // Reset values
  localparam logic [7:0] CTOC_MODE_RST   = 8'h00;
  localparam logic [7:0] CTOC_RELOAD_RST = 8'h00;

  // Status field positions
  localparam int CTOC_STAT_SHORT = 0; // Short counter expired
  localparam int CTOC_STAT_LONG  = 1; // Long counter expired

  // ****************************************************************
  // Mode codes
  // ****************************************************************
  localparam logic [7:0] CTOC_MODE_STOP    = 8'h00; // All halted
  localparam logic [7:0] CTOC_MODE_SHORT   = 8'h05; // Short only
  localparam logic [7:0] CTOC_MODE_LONG16  = 8'h61; // 16-bit now
  localparam logic [7:0] CTOC_MODE_BOTH    = 8'h65; // Short + 16-bit
  localparam logic [7:0] CTOC_MODE_CHAIN24 = 8'h68; // 24-bit now
  localparam logic [7:0] CTOC_MODE_START16 = 8'h71; // 16-bit on start

  // ****************************************************************
  // Types
  // ****************************************************************
  // Gray sequence idle, armed, running
  typedef enum logic [1:0] {
    CTOC_IDLE = 2'b00,
    CTOC_WAIT = 2'b01,
    CTOC_RUN  = 2'b11
  } ctoc_run_e;

  // Software visible configuration
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] low;
    logic [7:0] mid;
    logic [7:0] high;
  } ctoc_cfg_s;

  // Events from the card line side
  typedef struct packed {
    logic startBit; // Start bit seen on I/O, rx or tx
    logic etuTick;  // One elementary time unit elapsed
  } ctoc_link_s;

  // Expiry flags, also used for set and clear requests
  typedef struct packed {
    logic longExpired;
    logic shortExpired;
  } ctoc_flags_s;

  // Whole state of the top module
  typedef struct packed {
    ctoc_cfg_s cfg;
    ctoc_run_e shortState;
    ctoc_run_e longState;
  } ctoc_main_state_s;

endpackage : ctoc_pkg

// File: design/ctoc_down_counter.sv
// Purpose: Down counter with load, stop and optional auto-reload.
// Assumes: tick is a one-cycle pulse per elementary time unit.
// Notes:   Load of zero expires on the first tick.
`timescale 1ns/1ps
module ctoc_down_counter
  import ctoc_pkg::*;
#(
  parameter int unsigned W = 8 // Counter width
) (
  input  logic         clk,
  input  logic         reset,
  input  logic         load,       // Start count at loadValue
  input  logic         stop,       // Halt, wins over load
  input  logic         tick,       // Step enable
  input  logic         autoReload, // Restart after expiry
  input  logic [W-1:0] loadValue,
  output logic [W-1:0] count,
  output logic         running,
  output logic         expired     // One-cycle pulse
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         running;
    logic         expired;
  } ctoc_cnt_state_s;

  localparam logic [W-1:0] CNT_ONE = {{(W-1){1'b0}}, 1'b1};

  ctoc_cnt_state_s st;      // Registered state
  ctoc_cnt_state_s next_st; // Next state

  // Next state: stop, then load, then step
  always_comb begin
    next_st = st;
    next_st.expired = 1'b0;
    if (stop) begin
      next_st.running = 1'b0;
    end else if (load) begin
      next_st.cnt = loadValue;
      next_st.running = 1'b1;
    end else if (st.running && tick) begin
      if (st.cnt <= CNT_ONE) begin
        next_st.expired = 1'b1;
        // Reload uses the live value, so it must stay still
        if (autoReload) begin
          next_st.cnt = loadValue;
        end else begin
          next_st.running = 1'b0;
          next_st.cnt = '0;
        end
      end else begin
        next_st.cnt = st.cnt - CNT_ONE;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count   = st.cnt;
  assign running = st.running;
  assign expired = st.expired;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_tick_step: assert property (
    @(posedge clk) disable iff (reset)
    st.running && tick && st.cnt > CNT_ONE && !load && !stop
    |=> st.cnt == $past(st.cnt) - CNT_ONE)
    else $error("counter did not step by one on a tick");

  chk_auto_reload: assert property (
    @(posedge clk) disable iff (reset)
    st.expired && $past(autoReload)
    |-> st.running && st.cnt == $past(loadValue))
    else $error("auto-reload counter did not restart");

  chk_one_shot: assert property (
    @(posedge clk) disable iff (reset)
    st.expired && !$past(autoReload) |-> !st.running)
    else $error("one-shot counter kept running after expiry");

endmodule : ctoc_down_counter

// File: design/ctoc_status_flags.sv
// Purpose: Sticky expiry flags, cleared by writing one.
// Assumes: set and clear are one-cycle requests.
// Notes:   A set in the clearing cycle wins.
`timescale 1ns/1ps
module ctoc_status_flags
  import ctoc_pkg::*;
(
  input  logic        clk,
  input  logic        reset,
  input  ctoc_flags_s setReq,   // Expiry events
  input  ctoc_flags_s clearReq, // Write-one-to-clear bits
  output ctoc_flags_s flags
);

  // ****************************************************************
  // State
  // ****************************************************************
  ctoc_flags_s st;      // Registered flags
  ctoc_flags_s next_st; // Next flags

  // Set beats clear so an event is never lost
  always_comb begin
    next_st = st;
    next_st.shortExpired = (st.shortExpired && !clearReq.shortExpired)
                           || setReq.shortExpired;
    next_st.longExpired  = (st.longExpired && !clearReq.longExpired)
                           || setReq.longExpired;
  end

  // Flag register
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st;

  chk_set_wins: assert property (
    @(posedge clk) disable iff (reset)
    setReq.longExpired |=> st.longExpired)
    else $error("long expiry flag not set after event");

endmodule : ctoc_status_flags

// File: design/ctoc_card_timeout.sv
// Purpose: Card waiting time counters behind an APB register file.
// Assumes: Start bit and ETU tick are one-cycle synchronous pulses.
// Notes:   Zero-wait APB slave; unmapped words answer with pslverr.
`timescale 1ns/1ps
module ctoc_card_timeout
  import ctoc_pkg::*;
(
  input  logic        clk,
  input  logic        reset,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  ctoc_link_s  cardEvents,   // Start bit and ETU tick
  output ctoc_flags_s expiredPulse, // One-cycle expiry events
  output ctoc_flags_s statusFlags   // Sticky expiry flags
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic       access;    // APB access phase
  logic [5:0] wordIdx;   // Register index of the address
  logic       aligned;   // Word aligned address
  logic       mapped;    // Address hits a register
  logic       regWrite;  // Write taken this edge
  logic       modeWrite; // Mode register written this edge
  logic [7:0] writeCode; // Mode code being written

  assign access    = psel && penable;
  assign wordIdx   = paddr[7:2];
  assign aligned   = (paddr[1:0] == 2'b00);
  assign regWrite  = access && pwrite && mapped;
  assign modeWrite = regWrite && (wordIdx == CTOC_IDX_MODE);
  assign writeCode = pwdata[7:0];

  // Only five words are decoded, everything else is an error
  always_comb begin
    mapped = 1'b0;
    if (aligned) begin
      unique case (wordIdx)
        CTOC_IDX_MODE,
        CTOC_IDX_LOW,
        CTOC_IDX_MID,
        CTOC_IDX_HIGH,
        CTOC_IDX_STATUS: mapped = 1'b1;
        default:         mapped = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // State and counter control
  // ****************************************************************
  ctoc_main_state_s st;         // Registered state
  ctoc_main_state_s next_st;    // Next state
  logic             loadShort;  // Start the short counter
  logic             stopShort;  // Halt the short counter
  logic             loadLong;   // Start the long counter
  logic             stopLong;   // Halt the long counter
  logic [23:0]      longValue;  // Value loaded into the long counter
  logic [7:0]       shortCount; // Short counter value
  logic             shortRun;   // Short counter active
  logic [23:0]      longCount;  // Long counter value
  logic             longRun;    // Long counter active
  ctoc_flags_s      clearReq;   // Flag clear requests

  // Long counter takes the 24-bit chain only in code 68
  always_comb begin
    if (modeWrite && writeCode == CTOC_MODE_CHAIN24) begin
      longValue = {st.cfg.high, st.cfg.mid, st.cfg.low};
    end else begin
      longValue = {8'h00, st.cfg.high, st.cfg.mid};
    end
  end

  // Register writes, mode changes and start bit arming
  always_comb begin
    next_st   = st;
    loadShort = 1'b0;
    stopShort = 1'b0;
    loadLong  = 1'b0;
    stopLong  = 1'b0;
    clearReq  = '0;
    // Register file writes
    if (regWrite) begin
      unique case (wordIdx)
        CTOC_IDX_MODE: next_st.cfg.mode = writeCode;
        CTOC_IDX_LOW:  next_st.cfg.low  = pwdata[7:0];
        CTOC_IDX_MID:  next_st.cfg.mid  = pwdata[7:0];
        CTOC_IDX_HIGH: next_st.cfg.high = pwdata[7:0];
        CTOC_IDX_STATUS: begin
          clearReq.shortExpired = pwdata[CTOC_STAT_SHORT];
          clearReq.longExpired  = pwdata[CTOC_STAT_LONG];
        end
        default: ;
      endcase
    end
    if (modeWrite) begin
      // New mode acts at the same edge as the write
      unique case (writeCode)
        CTOC_MODE_STOP: begin
          stopShort = 1'b1;
          stopLong  = 1'b1;
          next_st.shortState = CTOC_IDLE;
          next_st.longState  = CTOC_IDLE;
        end
        CTOC_MODE_SHORT: begin
          stopLong = 1'b1;
          next_st.longState = CTOC_IDLE;
          // An idle short counter starts; a busy one carries on
          if (st.shortState == CTOC_IDLE) begin
            loadShort = 1'b1;
            next_st.shortState = CTOC_RUN;
          end
        end
        CTOC_MODE_LONG16: begin
          stopShort = 1'b1;
          loadLong  = 1'b1;
          next_st.shortState = CTOC_IDLE;
          next_st.longState  = CTOC_RUN;
        end
        CTOC_MODE_BOTH: begin
          stopShort = 1'b1;
          loadLong  = 1'b1;
          next_st.shortState = CTOC_WAIT;
          next_st.longState  = CTOC_RUN;
        end
        CTOC_MODE_CHAIN24: begin
          stopShort = 1'b1;
          loadLong  = 1'b1;
          next_st.shortState = CTOC_IDLE;
          next_st.longState  = CTOC_RUN;
        end
        CTOC_MODE_START16: begin
          stopShort = 1'b1;
          stopLong  = 1'b1;
          next_st.shortState = CTOC_IDLE;
          next_st.longState  = CTOC_WAIT;
        end
        default: begin
          // Undefined codes park everything in a safe state
          stopShort = 1'b1;
          stopLong  = 1'b1;
          next_st.shortState = CTOC_IDLE;
          next_st.longState  = CTOC_IDLE;
        end
      endcase
    end else begin
      // Short counter waits for the first start bit
      if (st.shortState == CTOC_WAIT && cardEvents.startBit) begin
        loadShort = 1'b1;
        next_st.shortState = CTOC_RUN;
      end
      // Long counter: start, restart or finish
      if (st.longState == CTOC_WAIT && cardEvents.startBit) begin
        loadLong = 1'b1;
        next_st.longState = CTOC_RUN;
      end else if (st.longState == CTOC_RUN
                   && st.cfg.mode == CTOC_MODE_START16
                   && cardEvents.startBit) begin
        loadLong = 1'b1;
      end else if (st.longState == CTOC_RUN && expiredPulse.longExpired)
      begin
        // Start bit mode rearms, the others end here
        if (st.cfg.mode == CTOC_MODE_START16) begin
          next_st.longState = CTOC_WAIT;
        end else begin
          next_st.longState = CTOC_IDLE;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st.cfg.mode   <= CTOC_MODE_RST;
      st.cfg.low    <= CTOC_RELOAD_RST;
      st.cfg.mid    <= CTOC_RELOAD_RST;
      st.cfg.high   <= CTOC_RELOAD_RST;
      st.shortState <= CTOC_IDLE;
      st.longState  <= CTOC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Reload bytes are write-only and read back as zero
  always_comb begin
    prdata = 32'h00000000;
    if (access && !pwrite && aligned) begin
      unique case (wordIdx)
        CTOC_IDX_MODE:   prdata = {24'h000000, st.cfg.mode};
        CTOC_IDX_STATUS: prdata = {30'h00000000,
                                   statusFlags.longExpired,
                                   statusFlags.shortExpired};
        default:         prdata = 32'h00000000;
      endcase
    end
  end

  // Zero-wait slave keeps the bus simple
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ****************************************************************
  // Counters and flags
  // ****************************************************************
  ctoc_down_counter #(
    .W          (8)
  ) u_short (
    .clk        (clk),
    .reset      (reset),
    .load       (loadShort),
    .stop       (stopShort),
    .tick       (cardEvents.etuTick),
    .autoReload (1'b1),
    .loadValue  (st.cfg.low),
    .count      (shortCount),
    .running    (shortRun),
    .expired    (expiredPulse.shortExpired)
  );

  ctoc_down_counter #(
    .W          (24)
  ) u_long (
    .clk        (clk),
    .reset      (reset),
    .load       (loadLong),
    .stop       (stopLong),
    .tick       (cardEvents.etuTick),
    .autoReload (1'b0),
    .loadValue  (longValue),
    .count      (longCount),
    .running    (longRun),
    .expired    (expiredPulse.longExpired)
  );

  ctoc_status_flags u_flags (
    .clk      (clk),
    .reset    (reset),
    .setReq   (expiredPulse),
    .clearReq (clearReq),
    .flags    (statusFlags)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_mode_reset: assert property (
    @(posedge clk) disable iff (reset)
    $fell(reset) |-> st.cfg.mode == CTOC_MODE_RST)
    else $error("mode register not zero after reset");

  chk_mode_readback: assert property (
    @(posedge clk) disable iff (reset)
    modeWrite |=> st.cfg.mode == $past(writeCode))
    else $error("mode register did not take the written code");

  chk_stop_all: assert property (
    @(posedge clk) disable iff (reset)
    modeWrite && writeCode == CTOC_MODE_STOP
    |=> !shortRun && !longRun && st.shortState == CTOC_IDLE
        && st.longState == CTOC_IDLE)
    else $error("code zero left a counter active");

  chk_short_only: assert property (
    @(posedge clk) disable iff (reset)
    modeWrite && writeCode == CTOC_MODE_SHORT
    |=> !longRun && st.shortState != CTOC_IDLE)
    else $error("code 05 did not keep only the short counter");

  chk_long16_start: assert property (
    @(posedge clk) disable iff (reset)
    modeWrite && writeCode == CTOC_MODE_LONG16
    |=> longRun && !shortRun
        && longCount == {8'h00, $past(st.cfg.high), $past(st.cfg.mid)})
    else $error("code 61 did not start the 16-bit count");

  chk_both_start: assert property (
    @(posedge clk) disable iff (reset)
    modeWrite && writeCode == CTOC_MODE_BOTH
    |=> longRun && !shortRun && st.shortState == CTOC_WAIT)
    else $error("code 65 did not start long and arm short");

  chk_short_arm: assert property (
    @(posedge clk) disable iff (reset)
    st.shortState == CTOC_WAIT && cardEvents.startBit && !modeWrite
    |=> shortRun && shortCount == $past(st.cfg.low))
    else $error("short counter did not start on start bit");

  chk_chain24_load: assert property (
    @(posedge clk) disable iff (reset)
    modeWrite && writeCode == CTOC_MODE_CHAIN24
    |=> longRun && longCount == {$past(st.cfg.high),
                                 $past(st.cfg.mid), $past(st.cfg.low)})
    else $error("code 68 did not load the 24-bit chain");

  chk_start16_arm: assert property (
    @(posedge clk) disable iff (reset)
    modeWrite && writeCode == CTOC_MODE_START16
    |=> !longRun && st.longState == CTOC_WAIT)
    else $error("code 71 started before a start bit");

  chk_start16_restart: assert property (
    @(posedge clk) disable iff (reset)
    st.longState != CTOC_IDLE && st.cfg.mode == CTOC_MODE_START16
    && cardEvents.startBit && !modeWrite
    |=> longRun
        && longCount == {8'h00, $past(st.cfg.high), $past(st.cfg.mid)})
    else $error("start bit did not reload the 16-bit count");

  chk_reload_wonly: assert property (
    @(posedge clk) disable iff (reset)
    access && !pwrite && aligned && wordIdx == CTOC_IDX_LOW
    |-> prdata == 32'h00000000)
    else $error("reload byte did not read as zero");

endmodule : ctoc_card_timeout

// File: testbench/ctoc_card_model.sv
// Purpose: Card side model, makes ETU ticks and start bits.
// Assumes: etuDiv is at least 4, so events never crowd.
// Notes:   etuDiv 4 is a prompt card, 7 a slow one.
`timescale 1ns/1ps
module ctoc_card_model
  import ctoc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       tickOn,   // Card clock running
  input  wire logic [3:0] etuDiv,   // Cycles per ETU
  input  wire logic       startReq, // Start bit on I/O
  output ctoc_link_s      events
);
  // ****************************************************
  // ETU divider
  // ****************************************************
  logic [3:0] div; // Prescaler, cleared while paused
  // Pausing clears the divider so a restart is a full ETU
  always_ff @(posedge clk) begin
    if (reset || !tickOn) begin
      div <= 4'h0;
    end else if (div == etuDiv - 4'h1) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end
  assign events.etuTick  = tickOn && (div == etuDiv - 4'h1);
  assign events.startBit = startReq; // Rx and tx look alike
endmodule : ctoc_card_model

// File: testbench/card_timeout_counter_test.sv
// Purpose: Self-checking bench of the card timeout counter.
// Assumes: Zero-wait APB slave, status word at 0x30.
// Notes:   Ticks pause around mode writes to keep edges apart.
`timescale 1ns/1ps
module card_timeout_counter_test
  import ctoc_pkg::*;
;
  // ****************************************************
  // Signals
  // ****************************************************
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e, tickOn, startReq;
  logic [3:0] etuDiv;
  ctoc_link_s link;   // Card events
  ctoc_flags_s pulse; // Expiry pulses
  ctoc_flags_s flags; // Sticky flags
  int n_mismatch, compares, tickCnt, shortCnt, longCnt, b, c, n;
  int seed = 32'h20da;

  ctoc_card_timeout dut_u (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cardEvents(link), .expiredPulse(pulse),
    .statusFlags(flags));
  ctoc_card_model card_u (.clk(clk), .reset(reset), .tickOn(tickOn),
    .etuDiv(etuDiv), .startReq(startReq), .events(link));

  always #50 clk = ~clk;
  // Count on the falling edge, where everything has settled
  always @(negedge clk) begin
    if (link.etuTick === 1'b1) tickCnt++;
    if (pulse.shortExpired === 1'b1) shortCnt++;
    if (pulse.longExpired === 1'b1) longCnt++;
  end

  // ****************************************************
  // Tasks
  // ****************************************************
  task chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer, idle cycle after so psel never flips twice
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, r, x);
  endtask : rdc
  // Ticks pause so a write edge never meets a tick
  task wrq(input logic [7:0] a, input logic [31:0] d);
    tickOn <= 1'b0; wr(a, d); tickOn <= 1'b1;
  endtask : wrq
  task mode(input logic [7:0] m);
    wrq(8'h20, {24'h0, m});
  endtask : mode
  task wait_ticks(input int k);
    int t;
    t = tickCnt + k;
    while (tickCnt < t) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : wait_ticks
  task start_bit();
    startReq <= 1'b1; @(posedge clk); startReq <= 1'b0;
  endtask : start_bit
  // Ticks to long expiry: 24-bit chain in code 68, else {high, mid}
  function automatic int long_len(input logic [7:0] m, h, md, l);
    return (m == CTOC_MODE_CHAIN24) ? {h, md, l} : {h, md};
  endfunction : long_len
  task long_case(input logic [7:0] m, h, md, l);
    int k;
    k = long_len(m, h, md, l);
    mode(8'h00);
    wr(8'h24, l); wr(8'h28, md); wr(8'h2c, h);
    mode(m); b = longCnt;
    wait_ticks(k - 1); chk("long early", longCnt - b, 0);
    wait_ticks(1); chk("long expiry", longCnt - b, 1);
    rdc("status", 8'h30, 2);
    chk("flag port", flags, 2);
    wr(8'h30, 3); rdc("status clr", 8'h30, 0);
  endtask : long_case
  task close_out();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; tickOn = 0; etuDiv = 4; startReq = 0;
    repeat (3) @(posedge clk); reset <= 1'b0; @(posedge clk);
    rdc("mode reset", 8'h20, 0);
    wr(8'h24, 8'h5a); rdc("low wo", 8'h24, 0);
    apb(1'b0, 8'h14, 32'h0); chk("unmapped", e, 1);
    mode(8'h68); rdc("mode rw", 8'h20, 8'h68);
    // Random small long counts in codes 61 and 68 on a prompt, then a slow card
    for (int i = 0; i < 2; i++) begin
      etuDiv <= i ? 4'h7 : 4'h4;
      n = 1 + ($random(seed) & 7);
      long_case(8'h61, 0, n[7:0], 0);
      long_case(8'h68, 0, 1, n[7:0]);
    end
    long_case(8'h61, 1, 0, 0);
    // Short counter alone, then halted
    mode(8'h00); wr(8'h24, 3); mode(8'h05); b = shortCnt; c = longCnt;
    wait_ticks(3); chk("short 05", shortCnt - b, 1);
    wait_ticks(3); chk("short reload", shortCnt - b, 2);
    chk("long 05", longCnt - c, 0);
    mode(8'h00); b = shortCnt;
    wait_ticks(4); chk("stop all", shortCnt - b, 0);
    // Short waits for a start bit, long runs from the write
    wr(8'h28, 20); wr(8'h2c, 0); mode(8'h65);
    b = shortCnt; c = longCnt;
    wait_ticks(4); chk("short armed", shortCnt - b, 0);
    start_bit();
    wait_ticks(9); chk("short runs", shortCnt - b, 3);
    wait_ticks(6); chk("long 65 early", longCnt - c, 0);
    wait_ticks(1); chk("long 65", longCnt - c, 1);
    mode(8'h00); b = shortCnt;
    wait_ticks(6); chk("65 stop", shortCnt - b, 0);
    // Code 05 parks the 16-bit count before new reloads go in
    mode(8'h65); wait_ticks(4); mode(8'h05); c = longCnt;
    wr(8'h28, 1); wait_ticks(20);
    chk("65 then 05", longCnt - c, 0);
    mode(8'h00);
    // Long counter started by every start bit
    wr(8'h30, 3); wr(8'h28, 5); mode(8'h71); c = longCnt;
    wait_ticks(6); chk("71 armed", longCnt - c, 0);
    start_bit(); wait_ticks(2); wrq(8'h28, 2);
    wait_ticks(2); chk("71 early", longCnt - c, 0);
    wait_ticks(1); chk("71 old value", longCnt - c, 1);
    start_bit(); wait_ticks(2); chk("71 new", longCnt - c, 2);
    close_out();
  end
  // Watchdog well beyond the longest expected run
  initial begin
    #(100 * 40000);
    n_mismatch++;
    close_out();
  end
endmodule : card_timeout_counter_test
